// *** hdl/converter_setpoint_command_bank.sv ***
// Word-wide converter setpoint command bank with its regulation-side decode
// Behaviour
// - Store voltage ceiling; refuse writes above 110% of strapped output voltage.
// - Margin-up word is the voltage target when margin-up is selected.
// - Margin-down word is the voltage target when margin-down is selected.
// - Setpoint slews at the stored linear rate: volts per millisecond in linear mode, whole codes per millisecond in other modes.
// - Hold load line slope word in millivolts per ampere.
// - Hold direct-format loop sense gain word.
// - Hold direct-format monitor divider scale word.
// - Limit duty cycle to the stored linear percentage.
// - Switching frequency set from a linear word in whole kilohertz.
// - Conversion starts once input voltage reaches the turn-on level.
// - Conversion stops once input voltage falls to the turn-off level.
// - Interleave bits 11:8 give the group identifier.
// - Interleave bits 7:4 give the unit count, sync source included.
// - Interleave bits 3:0 give phase position; sync source gets zero.
// - Current offset is added to output current readings; host may only read it.
// - Output voltage above the fault level declares over-voltage.
// - Output-mode words use mode byte: 000 is linear, 4:0 exponent.
`timescale 1ns/10ps
`include "setpoint_bank_defs.svh"

module converter_setpoint_command_bank import setpoint_bank_pkg::*; #(
	parameter int SLEW_TICK_CYCLES = `SLEW_TICK_NS / `SYS_CLK_NS
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [7:0] i_cmd_code,
	input wire logic i_wr_en,
	input wire word_type i_wr_data,
	input wire logic i_rd_en,
	input wire word_type i_strap_vout,
	input wire logic [7:0] i_vout_mode,
	input wire word_type i_vout_command,
	input wire margin_sel_type i_margin_sel,
	input wire word_type i_vin_reading,
	input wire word_type i_vout_reading,
	input wire word_type i_output_current_reading,
	input wire logic i_cal_offset_load,
	input wire word_type i_cal_offset_value,
	output word_type o_rd_data,
	output logic o_rd_valid,
	output logic o_cmd_nack,
	output word_type o_setpoint,
	output word_type o_load_line_slope,
	output word_type o_loop_sense_gain,
	output word_type o_monitor_sense_scale,
	output word_type o_duty_limit_pct,
	output word_type o_switch_khz,
	output logic o_conv_enable,
	output logic [3:0] o_group_id,
	output logic [3:0] o_rail_count,
	output logic [3:0] o_rail_position,
	output logic signed [39:0] o_output_current_corrected,
	output logic o_ov_fault
);

	////////////////////////////////////////////////////////////////////////////
	// Format helpers

	// Linear word to signed fixed point with eight fraction bits
	function automatic fixed_type lin_to_fixed(input word_type w);
		logic signed [4:0] e;
		logic signed [10:0] m;
		fixed_type base;
		int sh;
		e = w[`LIN_EXP_MSB:`LIN_EXP_LSB];
		m = w[`LIN_MANT_MSB:`LIN_MANT_LSB];
		base = fixed_type'(m);
		sh = int'(e) + `FIX_FRAC_BITS;
		if (sh >= 0) begin
			lin_to_fixed = base <<< sh;
		end else begin
			lin_to_fixed = base >>> (-sh);
		end
	endfunction : lin_to_fixed

	// Fixed point to whole units, saturated into an unsigned word
	function automatic word_type fixed_to_word(input fixed_type f);
		fixed_type whole;
		whole = f >>> `FIX_FRAC_BITS;
		if (whole < 0) begin
			fixed_to_word = `RST_WORD;
		end else if (whole > fixed_type'(16'hFFFF)) begin
			fixed_to_word = 16'hFFFF;
		end else begin
			fixed_to_word = whole[15:0];
		end
	endfunction : fixed_to_word

	////////////////////////////////////////////////////////////////////////////
	// Storage

	word_type ceiling_reg;
	word_type margin_up_reg;
	word_type margin_down_reg;
	word_type slew_rate_reg;
	word_type load_line_reg;
	word_type loop_gain_reg;
	word_type monitor_scale_reg;
	word_type duty_limit_reg;
	word_type switch_rate_reg;
	word_type turn_on_reg;
	word_type turn_off_reg;
	word_type interleave_reg;
	word_type cal_offset_reg;
	word_type ov_level_reg;
	word_type strap_reg;
	logic ceiling_init_reg;
	word_type rd_data_reg;
	logic rd_valid_reg;
	logic nack_reg;
	logic conv_enable_reg;
	logic ov_fault_reg;
	word_type duty_pct_reg;
	word_type switch_khz_reg;
	logic signed [39:0] output_current_corr_reg;
	logic [31:0] tick_cnt_reg;
	logic tick_reg;

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	logic known_code;
	logic ro_code;
	logic ceiling_too_high;
	logic wr_accept;
	logic wr_refuse;
	word_type rd_mux;
	logic [19:0] ceil_scaled;
	logic [19:0] strap_scaled;

	// Value times ten against strap times eleven avoids a divider
	assign ceil_scaled = {4'h0, i_wr_data} * `CEIL_RATIO_DEN;
	assign strap_scaled = {4'h0, strap_reg} * `CEIL_RATIO_NUM;
	assign ceiling_too_high = (i_cmd_code == `CMD_OUTPUT_VOLTAGE_CEILING) && (ceil_scaled > strap_scaled);

	assign ro_code = (i_cmd_code == `CMD_CURRENT_READING_OFFSET);
	assign wr_accept = i_wr_en && known_code && !ro_code && !ceiling_too_high;
	assign wr_refuse = i_wr_en && !wr_accept;

	// Readback selection; unknown codes read as zero and are refused
	always_comb begin
		known_code = 1'b1;
		rd_mux = `RST_WORD;
		unique case (i_cmd_code)
			`CMD_OUTPUT_VOLTAGE_CEILING: rd_mux = ceiling_reg;
			`CMD_MARGIN_UP_TARGET: rd_mux = margin_up_reg;
			`CMD_MARGIN_DOWN_TARGET: rd_mux = margin_down_reg;
			`CMD_SETPOINT_SLEW_RATE: rd_mux = slew_rate_reg;
			`CMD_LOAD_LINE_SLOPE: rd_mux = load_line_reg;
			`CMD_LOOP_SENSE_GAIN: rd_mux = loop_gain_reg;
			`CMD_MONITOR_SENSE_SCALE: rd_mux = monitor_scale_reg;
			`CMD_DUTY_CYCLE_LIMIT: rd_mux = duty_limit_reg;
			`CMD_SWITCHING_RATE: rd_mux = switch_rate_reg;
			`CMD_INPUT_TURN_ON_LEVEL: rd_mux = turn_on_reg;
			`CMD_INPUT_TURN_OFF_LEVEL: rd_mux = turn_off_reg;
			`CMD_PHASE_SPREADING_CONFIG: rd_mux = interleave_reg;
			`CMD_CURRENT_READING_OFFSET: rd_mux = cal_offset_reg;
			`CMD_OVERVOLTAGE_FAULT_LEVEL: rd_mux = ov_level_reg;
			default: known_code = 1'b0;
		endcase
	end

	// Strap is caught while reset is held; ceiling starts at the strap value
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			strap_reg <= i_strap_vout;
			ceiling_init_reg <= 1'b1;
		end else if (i_clk_en) begin
			ceiling_init_reg <= 1'b0;
		end
	end

	// Register writes, one whole word per command
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			ceiling_reg <= `RST_WORD;
			margin_up_reg <= `RST_WORD;
			margin_down_reg <= `RST_WORD;
			slew_rate_reg <= `RST_WORD;
			load_line_reg <= `RST_WORD;
			loop_gain_reg <= `RST_WORD;
			monitor_scale_reg <= `RST_WORD;
			duty_limit_reg <= `RST_WORD;
			switch_rate_reg <= `RST_WORD;
			turn_on_reg <= `RST_WORD;
			turn_off_reg <= `RST_WORD;
			interleave_reg <= `RST_INTERLEAVE;
			ov_level_reg <= `RST_WORD;
		end else if (i_clk_en) begin
			if (ceiling_init_reg) begin
				ceiling_reg <= strap_reg;
			end
			if (wr_accept) begin
				unique case (i_cmd_code)
					`CMD_OUTPUT_VOLTAGE_CEILING: ceiling_reg <= i_wr_data;
					`CMD_MARGIN_UP_TARGET: margin_up_reg <= i_wr_data;
					`CMD_MARGIN_DOWN_TARGET: margin_down_reg <= i_wr_data;
					`CMD_SETPOINT_SLEW_RATE: slew_rate_reg <= i_wr_data;
					`CMD_LOAD_LINE_SLOPE: load_line_reg <= i_wr_data;
					`CMD_LOOP_SENSE_GAIN: loop_gain_reg <= i_wr_data;
					`CMD_MONITOR_SENSE_SCALE: monitor_scale_reg <= i_wr_data;
					`CMD_DUTY_CYCLE_LIMIT: duty_limit_reg <= i_wr_data;
					`CMD_SWITCHING_RATE: switch_rate_reg <= i_wr_data;
					`CMD_INPUT_TURN_ON_LEVEL: turn_on_reg <= i_wr_data;
					`CMD_INPUT_TURN_OFF_LEVEL: turn_off_reg <= i_wr_data;
					`CMD_PHASE_SPREADING_CONFIG: interleave_reg <= i_wr_data;
					`CMD_OVERVOLTAGE_FAULT_LEVEL: ov_level_reg <= i_wr_data;
					default: ;
				endcase
			end
		end
	end

	// Read-only offset: loaded from calibration storage, never by the host
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			cal_offset_reg <= `RST_CAL_OFFSET;
		end else if (i_clk_en && i_cal_offset_load) begin
			cal_offset_reg <= i_cal_offset_value;
		end
	end

	// Read answer and refusal pulses, one cycle after the request
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			rd_data_reg <= `RST_WORD;
			rd_valid_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else if (i_clk_en) begin
			rd_valid_reg <= i_rd_en && known_code;
			nack_reg <= wr_refuse || (i_rd_en && !known_code);
			if (i_rd_en) begin
				rd_data_reg <= rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Setpoint path

	word_type target_raw;
	word_type target_clamped;
	word_type slew_step;
	word_type slewed_level;
	logic mode_linear;
	logic signed [4:0] vout_exp;
	fixed_type rate_fixed;
	fixed_type rate_code;
	int code_shift;

	// Margin selection picks the target word
	assign target_raw = (i_margin_sel == MARGIN_UP) ? margin_up_reg :
		(i_margin_sel == MARGIN_DOWN) ? margin_down_reg : i_vout_command;
	// Ceiling wins over every target, margins included
	assign target_clamped = (target_raw > ceiling_reg) ? ceiling_reg : target_raw;

	// Non-linear modes carry no exponent, so codes are taken as whole units
	assign mode_linear = (i_vout_mode[`MODE_SEL_MSB:`MODE_SEL_LSB] == `MODE_SEL_LINEAR);
	assign vout_exp = mode_linear ? i_vout_mode[`MODE_EXP_MSB:`MODE_EXP_LSB] : 5'sh00;

	// Volts per ms into output codes per tick: scale by two to minus exponent
	assign rate_fixed = lin_to_fixed(slew_rate_reg);
	assign code_shift = -int'(vout_exp);
	assign rate_code = (code_shift >= 0) ? (rate_fixed <<< code_shift) : (rate_fixed >>> (-code_shift));
	assign slew_step = fixed_to_word(rate_code);

	// Millisecond tick for the slew; rate is whole codes per tick, so tiny rates truncate
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			tick_cnt_reg <= 32'h00000000;
			tick_reg <= 1'b0;
		end else if (i_clk_en) begin
			tick_reg <= (tick_cnt_reg == 32'(SLEW_TICK_CYCLES - 1));
			tick_cnt_reg <= (tick_cnt_reg == 32'(SLEW_TICK_CYCLES - 1)) ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
		end
	end

	setpoint_slew u_slew (
		.i_sys_clk(i_sys_clk),
		.i_rst_n(i_rst_n),
		.i_clk_en(i_clk_en),
		.i_target(target_clamped),
		.i_step(slew_step),
		.i_tick(tick_reg),
		.o_level(slewed_level)
	);

	////////////////////////////////////////////////////////////////////////////
	// Regulation-side decode

	fixed_type vin_fixed;
	fixed_type on_fixed;
	fixed_type off_fixed;
	fixed_type output_current_sum;

	assign vin_fixed = lin_to_fixed(i_vin_reading);
	assign on_fixed = lin_to_fixed(turn_on_reg);
	assign off_fixed = lin_to_fixed(turn_off_reg);
	assign output_current_sum = lin_to_fixed(i_output_current_reading) + lin_to_fixed(cal_offset_reg);

	// Hysteresis: turn-on level starts, turn-off level stops once running
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			conv_enable_reg <= 1'b0;
		end else if (i_clk_en) begin
			if (!conv_enable_reg && vin_fixed >= on_fixed) begin
				conv_enable_reg <= 1'b1;
			end else if (conv_enable_reg && vin_fixed <= off_fixed) begin
				conv_enable_reg <= 1'b0;
			end
		end
	end

	// Decoded limits and readings, registered so outputs come from flops
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			duty_pct_reg <= `RST_WORD;
			switch_khz_reg <= `RST_WORD;
			output_current_corr_reg <= 40'sh0000000000;
			ov_fault_reg <= 1'b0;
		end else if (i_clk_en) begin
			duty_pct_reg <= fixed_to_word(lin_to_fixed(duty_limit_reg));
			switch_khz_reg <= fixed_to_word(lin_to_fixed(switch_rate_reg));
			output_current_corr_reg <= output_current_sum;
			ov_fault_reg <= (i_vout_reading > ov_level_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign o_rd_data = rd_data_reg;
	assign o_rd_valid = rd_valid_reg;
	assign o_cmd_nack = nack_reg;
	assign o_setpoint = slewed_level;
	assign o_load_line_slope = load_line_reg;
	assign o_loop_sense_gain = loop_gain_reg;
	assign o_monitor_sense_scale = monitor_scale_reg;
	assign o_duty_limit_pct = duty_pct_reg;
	assign o_switch_khz = switch_khz_reg;
	assign o_conv_enable = conv_enable_reg;
	assign o_group_id = interleave_reg[`GROUP_ID_MSB:`GROUP_ID_LSB];
	assign o_rail_count = interleave_reg[`RAIL_COUNT_MSB:`RAIL_COUNT_LSB];
	assign o_rail_position = interleave_reg[`RAIL_POS_MSB:`RAIL_POS_LSB];
	assign o_output_current_corrected = output_current_corr_reg;
	assign o_ov_fault = ov_fault_reg;

endmodule : converter_setpoint_command_bank

// *** hdl/setpoint_bank_defs.svh ***
// Command codes, field positions, reset values and timing for the setpoint bank
`ifndef SETPOINT_BANK_DEFS_SVH
`define SETPOINT_BANK_DEFS_SVH

// Command codes
`define CMD_OUTPUT_VOLTAGE_CEILING 8'h24
`define CMD_MARGIN_UP_TARGET 8'h25
`define CMD_MARGIN_DOWN_TARGET 8'h26
`define CMD_SETPOINT_SLEW_RATE 8'h27
`define CMD_LOAD_LINE_SLOPE 8'h28
`define CMD_LOOP_SENSE_GAIN 8'h29
`define CMD_MONITOR_SENSE_SCALE 8'h2A
`define CMD_DUTY_CYCLE_LIMIT 8'h32
`define CMD_SWITCHING_RATE 8'h33
`define CMD_INPUT_TURN_ON_LEVEL 8'h35
`define CMD_INPUT_TURN_OFF_LEVEL 8'h36
`define CMD_PHASE_SPREADING_CONFIG 8'h37
`define CMD_CURRENT_READING_OFFSET 8'h39
`define CMD_OVERVOLTAGE_FAULT_LEVEL 8'h40

// Interleave word fields
`define GROUP_ID_MSB 11
`define GROUP_ID_LSB 8
`define RAIL_COUNT_MSB 7
`define RAIL_COUNT_LSB 4
`define RAIL_POS_MSB 3
`define RAIL_POS_LSB 0

// Linear word and output mode byte fields
`define LIN_EXP_MSB 15
`define LIN_EXP_LSB 11
`define LIN_MANT_MSB 10
`define LIN_MANT_LSB 0
`define MODE_SEL_MSB 7
`define MODE_SEL_LSB 5
`define MODE_EXP_MSB 4
`define MODE_EXP_LSB 0
`define MODE_SEL_LINEAR 3'h0
`define FIX_FRAC_BITS 8

// Ceiling limit as a ratio: accepted if value * DEN <= strap * NUM
`define CEIL_RATIO_NUM 20'h0000B
`define CEIL_RATIO_DEN 20'h0000A

// Reset values
`define RST_WORD 16'h0000
`define RST_INTERLEAVE 16'h0000
`define RST_CAL_OFFSET 16'h0000

// Slew tick timing
`define SLEW_TICK_NS 1000000
`define SYS_CLK_NS 50

`endif

// *** hdl/setpoint_bank_pkg.sv ***
// Types shared by the setpoint bank modules
package setpoint_bank_pkg;

	// Operating target selection
	typedef enum logic [1:0] {
		MARGIN_NONE,
		MARGIN_UP,
		MARGIN_DOWN
	} margin_sel_type;

	typedef logic [15:0] word_type;
	typedef logic signed [39:0] fixed_type;

endpackage : setpoint_bank_pkg

// *** hdl/setpoint_slew.sv ***
// Rate-limited ramp of the output voltage setpoint
`timescale 1ns/10ps
`include "setpoint_bank_defs.svh"

module setpoint_slew import setpoint_bank_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire word_type i_target,
	input wire word_type i_step,
	input wire logic i_tick,
	output word_type o_level
);

	word_type level_reg;
	word_type level_next;
	logic [16:0] up_sum;
	logic [16:0] down_diff;
	logic going_up;
	logic going_down;

	// Step of zero means the setpoint jumps straight to target
	assign up_sum = {1'b0, level_reg} + {1'b0, i_step};
	assign down_diff = {1'b0, level_reg} - {1'b0, i_step};
	assign going_up = (i_target > level_reg);
	assign going_down = (i_target < level_reg);

	// Never overshoot: the last step lands exactly on target
	always_comb begin
		level_next = level_reg;
		if (i_step == `RST_WORD) begin
			level_next = i_target;
		end else if (i_tick && going_up) begin
			level_next = (up_sum[16] || up_sum[15:0] > i_target) ? i_target : up_sum[15:0];
		end else if (i_tick && going_down) begin
			level_next = (down_diff[16] || down_diff[15:0] < i_target) ? i_target : down_diff[15:0];
		end
	end

	// Level register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			level_reg <= `RST_WORD;
		end else if (i_clk_en) begin
			level_reg <= level_next;
		end
	end

	assign o_level = level_reg;

endmodule : setpoint_slew

// *** dv/setpoint_bank_sva.sv ***
// Concurrent checks on the setpoint bank command port and decode outputs
`timescale 1ns/10ps
`include "setpoint_bank_defs.svh"

module setpoint_bank_checker import setpoint_bank_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic [7:0] i_cmd_code,
	input wire logic i_wr_en,
	input wire word_type i_wr_data,
	input wire logic i_rd_en,
	input wire word_type i_strap_vout,
	input wire word_type i_vout_reading,
	input wire word_type o_rd_data,
	input wire logic o_rd_valid,
	input wire logic o_cmd_nack,
	input wire logic [3:0] o_group_id,
	input wire logic [3:0] o_rail_count,
	input wire logic [3:0] o_rail_position,
	input wire logic o_ov_fault
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	////////////////////////////////////////
	// Shadow state; strap is latched only in reset, as the bank does
	word_type strap_reg;
	word_type ov_level_reg;
	word_type wr_data_reg;
	wire logic cmd_known = i_cmd_code inside {8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h32, 8'h33,
		8'h35, 8'h36, 8'h37, 8'h39, 8'h40};
	wire logic ceil_over = ({4'h0, i_wr_data} * `CEIL_RATIO_DEN) > ({4'h0, strap_reg} * `CEIL_RATIO_NUM);
	wire logic wr_field = i_clk_en && i_wr_en && (i_cmd_code == `CMD_PHASE_SPREADING_CONFIG);
	wire logic ov_hit = i_vout_reading > ov_level_reg;

	// Mirror of the fault level and last write word
	always_ff @(posedge i_sys_clk) begin
		wr_data_reg <= i_wr_data;
		if (!i_rst_n) begin
			strap_reg <= i_strap_vout;
			ov_level_reg <= `RST_WORD;
		end else if (i_clk_en && i_wr_en && i_cmd_code == `CMD_OVERVOLTAGE_FAULT_LEVEL) begin
			ov_level_reg <= i_wr_data;
		end
	end

	////////////////////////////////////////
	// Request shapes
	sequence rd_req_s;
		i_clk_en && i_rd_en && !i_wr_en && cmd_known;
	endsequence
	sequence rd_bad_s;
		i_clk_en && i_rd_en && !i_wr_en && !cmd_known;
	endsequence

	rd_answer_a: assert property (rd_req_s |=> o_rd_valid && !o_cmd_nack)
		else $error("read not answered");
	rd_cause_a: assert property (o_rd_valid && $past(i_clk_en) |-> $past(i_rd_en))
		else $error("read valid without request");
	unknown_nack_a: assert property (rd_bad_s |=> o_cmd_nack && !o_rd_valid && o_rd_data == 16'h0000)
		else $error("unknown read not refused");
	ro_refuse_a: assert property (i_clk_en && i_wr_en && i_cmd_code == `CMD_CURRENT_READING_OFFSET |=> o_cmd_nack)
		else $error("offset write accepted");
	ceil_refuse_a: assert property (i_clk_en && i_wr_en && i_cmd_code == `CMD_OUTPUT_VOLTAGE_CEILING && ceil_over
		|=> o_cmd_nack)
		else $error("ceiling above limit accepted");
	group_field_a: assert property (wr_field |=> o_group_id == wr_data_reg[11:8])
		else $error("group id field wrong");
	count_field_a: assert property (wr_field |=> o_rail_count == wr_data_reg[7:4])
		else $error("rail count field wrong");
	position_field_a: assert property (wr_field |=> o_rail_position == wr_data_reg[3:0])
		else $error("rail position field wrong");
	group_hold_a: assert property (!wr_field |=> $stable(o_group_id) && $stable(o_rail_count)
		&& $stable(o_rail_position))
		else $error("interleave fields moved");
	ov_level_a: assert property (i_clk_en |=> o_ov_fault == $past(ov_hit))
		else $error("over-voltage flag wrong");
endmodule : setpoint_bank_checker

bind converter_setpoint_command_bank setpoint_bank_checker u_checker (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
	.i_clk_en(i_clk_en), .i_cmd_code(i_cmd_code), .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en),
	.i_strap_vout(i_strap_vout), .i_vout_reading(i_vout_reading), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
	.o_cmd_nack(o_cmd_nack), .o_group_id(o_group_id), .o_rail_count(o_rail_count),
	.o_rail_position(o_rail_position), .o_ov_fault(o_ov_fault));

// *** dv/host_word_master.sv ***
// Host side model issuing whole word commands to the bank
`timescale 1ns/10ps

module host_word_master import setpoint_bank_pkg::*; (
	input wire logic i_sys_clk,
	input wire word_type i_rd_data,
	input wire logic i_rd_valid,
	input wire logic i_cmd_nack,
	output logic [7:0] o_cmd_code,
	output logic o_wr_en,
	output word_type o_wr_data,
	output logic o_rd_en
);
	////////////////////////////////////////
	// Idle bus at time zero
	initial begin
		o_cmd_code = 8'h00;
		o_wr_en = 1'b0;
		o_wr_data = 16'h0000;
		o_rd_en = 1'b0;
	end

	// One word per request; released data shows its inverse so stale words never match
	task automatic xfer(input logic [7:0] code, input logic wr, input word_type data,
		output word_type rdata, output logic valid, output logic nack);
		@(posedge i_sys_clk);
		o_cmd_code <= code;
		o_wr_en <= wr;
		o_rd_en <= !wr;
		o_wr_data <= data;
		@(posedge i_sys_clk);
		o_wr_en <= 1'b0;
		o_rd_en <= 1'b0;
		o_wr_data <= ~data;
		o_cmd_code <= ~code;
		@(posedge i_sys_clk);
		rdata = i_rd_data;
		valid = i_rd_valid;
		nack = i_cmd_nack;
	endtask : xfer
endmodule : host_word_master

// *** dv/tb_top.sv ***
// Self-checking bench for the converter setpoint command bank
`timescale 1ns/10ps

module tb_top import setpoint_bank_pkg::*; ;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	word_type strap = 16'h1000;
	logic [7:0] vmode = 8'h18;
	word_type vcmd = 16'h0C00;
	margin_sel_type msel = MARGIN_NONE;
	word_type vin = 16'h0000;
	word_type vout = 16'h0000;
	word_type output_current = 16'h0002;
	logic cal_ld = 1'b0;
	logic en = 1'b1;
	word_type cal_val = 16'h0000;
	wire logic [7:0] cmd;
	wire logic wr_en;
	wire logic rd_en;
	wire word_type wr_data;
	word_type rd_data, setpoint, slope, gain, scale, duty, khz;
	logic rd_valid, nack, conv, ov, seen;
	logic [3:0] grp, cnt, pos;
	logic signed [39:0] output_current_c;
	int err_total = 0;
	int check_count = 0;
	int n;
	logic [7:0] codes [12] = '{8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h32, 8'h33, 8'h35, 8'h36, 8'h37, 8'h40};
	word_type vals [12] = '{16'h0F00, 16'h0D00, 16'h0000, 16'h0123, 16'h0456, 16'h0789, 16'h0050, 16'h01F4,
		16'h0030, 16'h0020, 16'h0A31, 16'h1000};

	// 20 MHz system clock
	always #25 clk = ~clk;

	converter_setpoint_command_bank #(.SLEW_TICK_CYCLES(8)) DUT (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(en),
		.i_cmd_code(cmd), .i_wr_en(wr_en), .i_wr_data(wr_data), .i_rd_en(rd_en), .i_strap_vout(strap),
		.i_vout_mode(vmode), .i_vout_command(vcmd), .i_margin_sel(msel), .i_vin_reading(vin),
		.i_vout_reading(vout), .i_output_current_reading(output_current), .i_cal_offset_load(cal_ld), .i_cal_offset_value(cal_val),
		.o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_cmd_nack(nack), .o_setpoint(setpoint),
		.o_load_line_slope(slope), .o_loop_sense_gain(gain), .o_monitor_sense_scale(scale),
		.o_duty_limit_pct(duty), .o_switch_khz(khz), .o_conv_enable(conv), .o_group_id(grp),
		.o_rail_count(cnt), .o_rail_position(pos), .o_output_current_corrected(output_current_c), .o_ov_fault(ov));

	host_word_master host (.i_sys_clk(clk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .i_cmd_nack(nack),
		.o_cmd_code(cmd), .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en));

	////////////////////////////////////////
	// Compare, report and finish
	task automatic chk(input word_type got, input word_type exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH time=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("checks=%0d mismatches=%0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out

	// Word write and read with expected refusal
	task automatic wr(input logic [7:0] code, input word_type data, input logic exp_nack);
		word_type d;
		logic v;
		logic k;
		host.xfer(code, 1'b1, data, d, v, k);
		chk({15'h0000, k}, {15'h0000, exp_nack});
	endtask : wr

	task automatic rd(input logic [7:0] code, input word_type exp, input logic exp_nack);
		word_type d;
		logic v;
		logic k;
		host.xfer(code, 1'b0, 16'h0000, d, v, k);
		chk({14'h0000, v, k}, {14'h0000, !exp_nack, exp_nack});
		chk(d, exp);
	endtask : rd

	task automatic cyc(input int c);
		repeat (c) @(posedge clk);
	endtask : cyc

	// Bounded wait for the ramp, noting the halfway step
	task automatic wait_sp(input word_type exp);
		n = 0;
		while (setpoint !== exp && n < 40) begin
			@(posedge clk);
			seen = seen | (setpoint === 16'h0E00);
			n++;
		end
		if (setpoint !== exp) begin
			err_total++;
			close_out();
		end
	endtask : wait_sp

	////////////////////////////////////////
	// Main sequence
	initial begin
		cyc(6);
		rst_n <= 1'b1;
		cyc(2);
		rd(8'h24, 16'h1000, 1'b0);
		wr(8'h24, 16'h119A, 1'b1);
		wr(8'h24, 16'h1199, 1'b0);
		rd(8'h24, 16'h1199, 1'b0);
		foreach (codes[i]) begin
			rd(codes[i], 16'h0000, 1'b0);
			wr(codes[i], vals[i], 1'b0);
			rd(codes[i], vals[i], 1'b0);
		end
		chk(slope, 16'h0123);
		chk(gain, 16'h0456);
		chk(scale, 16'h0789);
		chk(duty, 16'h0050);
		chk(khz, 16'h01F4);
		chk({4'h0, grp, cnt, pos}, 16'h0A31);
		// Frozen bank must ignore a write while the enable is low
		en <= 1'b0;
		wr(8'h28, 16'h0999, 1'b0);
		en <= 1'b1;
		rd(8'h28, 16'h0123, 1'b0);
		wr(8'h39, 16'h0007, 1'b1);
		rd(8'h39, 16'h0000, 1'b0);
		cal_val <= 16'h0004;
		cal_ld <= 1'b1;
		cyc(1);
		cal_ld <= 1'b0;
		rd(8'h39, 16'h0004, 1'b0);
		chk(output_current_c[15:0], 16'h0600);
		chk(output_current_c[31:16], 16'h0000);
		rd(8'h30, 16'h0000, 1'b1);
		wr(8'h30, 16'h1234, 1'b1);
		chk(setpoint, 16'h0C00);
		msel <= MARGIN_UP;
		cyc(3);
		chk(setpoint, 16'h0F00);
		msel <= MARGIN_DOWN;
		cyc(3);
		chk(setpoint, 16'h0D00);
		wr(8'h25, 16'h1500, 1'b0);
		msel <= MARGIN_UP;
		cyc(3);
		chk(setpoint, 16'h1199);
		msel <= MARGIN_DOWN;
		wr(8'h25, 16'h0F00, 1'b0);
		wr(8'h27, 16'h0001, 1'b0);
		seen = 1'b0;
		msel <= MARGIN_UP;
		wait_sp(16'h0F00);
		chk({15'h0000, seen}, 16'h0001);
		chk({15'h0000, n >= 8 && n <= 20}, 16'h0001);
		// Non-linear mode: exponent bits ignored, so the step stays whole codes
		vmode <= 8'h58;
		wr(8'h27, 16'h0100, 1'b0);
		seen = 1'b0;
		msel <= MARGIN_DOWN;
		wait_sp(16'h0D00);
		chk({15'h0000, seen && n >= 8 && n <= 20}, 16'h0001);
		vin <= 16'h0028;
		cyc(3);
		chk({15'h0000, conv}, 16'h0000);
		vin <= 16'h0030;
		cyc(3);
		chk({15'h0000, conv}, 16'h0001);
		vin <= 16'h0028;
		cyc(3);
		chk({15'h0000, conv}, 16'h0001);
		vin <= 16'h0020;
		cyc(3);
		chk({15'h0000, conv}, 16'h0000);
		vout <= 16'h1000;
		cyc(3);
		chk({15'h0000, ov}, 16'h0000);
		vout <= 16'h1001;
		cyc(3);
		chk({15'h0000, ov}, 16'h0001);
		close_out();
	end
endmodule : tb_top
